// File: hw/uv_pkg.sv
// Constants and types for the three-phase undervoltage element.
// Assumes a 50 MHz system clock and an APB register port.
package uv_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned MS_CNT_W = 16;

   // Register byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_DELAY = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_VOLT_A = 8'h18;
   localparam logic [7:0] OFS_VOLT_B = 8'h1C;
   localparam logic [7:0] OFS_VOLT_C = 8'h20;

   // Voltage magnitudes: percent of rated voltage times 256
   localparam int unsigned VOLT_W = 16;
   localparam int unsigned PCT_FRAC = 8;

   // Control and threshold field positions
   localparam int unsigned CTRL_OPER_LSB = 0;
   localparam int unsigned CTRL_STONLY_BIT = 2;
   localparam int unsigned THR_START_LSB = 0;
   localparam int unsigned THR_BLOCK_LSB = 8;

   // Setting ranges and defaults
   localparam logic [7:0] START_PCT_MIN = 8'h1E;
   localparam logic [7:0] START_PCT_MAX = 8'h82;
   localparam logic [7:0] START_PCT_DEF = 8'h34;
   localparam logic [7:0] BLOCK_PCT_MAX = 8'h14;
   localparam logic [7:0] BLOCK_PCT_DEF = 8'h0A;
   localparam logic [15:0] DELAY_MS_MAX = 16'hEA60;
   localparam logic [15:0] DELAY_MS_DEF = 16'h0064;

   // Interrupt bits
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_START_BIT = 0;
   localparam int unsigned IRQ_TRIP_BIT = 1;

   typedef enum logic [1:0] {
      OPER_OFF,
      OPER_ONE_OF_3,
      OPER_TWO_OF_3,
      OPER_ALL
   } oper_e;
endpackage : uv_pkg

// File: hw/uv_phase_cmp.sv
// One phase start comparator.
// Assumes magnitude and thresholds are on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uv_phase_cmp
   import uv_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Measurement and settings
   input wire logic [VOLT_W-1:0] magnitude,
   input wire logic [7:0] start_pct,
   input wire logic [7:0] block_pct,
   input wire logic enable,
   // Result
   output logic started
);
   logic [VOLT_W-1:0] start_lvl;
   logic [VOLT_W-1:0] block_lvl;

   assign start_lvl = {start_pct, {PCT_FRAC{1'b0}}};
   assign block_lvl = {block_pct, {PCT_FRAC{1'b0}}};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         started <= 1'b0;
      end else begin
         started <= enable && (magnitude < start_lvl) &&
                    (magnitude > block_lvl);
      end
   end
endmodule : uv_phase_cmp
`default_nettype wire

// File: hw/uv_element.sv
// Three-phase definite-time undervoltage element with APB registers.
// Assumes RMS magnitudes arrive on clk_sys from an upstream stage.
//
// Contract
// - Inputs are RMS fundamental magnitudes from an upstream stage.
// - Each phase has its own independent start output.
// - Phase starts while below start level and above blocking level.
// - Selector off, one-of-three, two-of-three, all; defaults one-of-three.
// - Trip only when delay expired while started and not start-only.
// - One binary disable input suppresses all operation.
// - Start threshold 30 to 130 percent, step one, default 52.
// - Blocking threshold 0 to 20 percent, step one, default 10.
// - Trip delay 0 to 60000 ms, step one, default 100.
// - Start-only option reports starts but never trips; default false.
// - Start drop-out within 50 ms; minimum operate time 50 ms (here a zero delay trips one cycle after general start).
`timescale 1ns/1ps
`default_nettype none
module uv_element
   import uv_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measured magnitudes
   input wire logic [VOLT_W-1:0] phase_a_fundamental_rms,
   input wire logic [VOLT_W-1:0] phase_b_fundamental_rms,
   input wire logic [VOLT_W-1:0] phase_c_fundamental_rms,
   // External disable
   input wire logic element_disable,
   // Outputs
   output logic start_a,
   output logic start_b,
   output logic start_c,
   output logic general_start,
   output logic trip,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   // Registers
   oper_e operation_selector_reg;
   logic start_only_option_reg;
   logic [7:0] start_threshold_pct_reg;
   logic [7:0] blocking_threshold_pct_reg;
   logic [15:0] trip_delay_ms_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [31:0] prdata_next;
   logic addr_ok;
   logic wr_en;
   logic rd_en;
   logic active;
   logic [2:0] ph_start;
   logic [1:0] ph_count;
   logic gen_start_next;
   logic [15:0] ms_count_reg;
   logic [MS_CNT_W-1:0] ms_tick_cnt_reg;
   logic ms_tick;
   logic expired;
   logic general_start_d_reg;
   logic trip_d_reg;
   logic [7:0] wr_start;
   logic [7:0] wr_block;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_comb begin
      addr_ok = 1'b1;
      prdata_next = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL: begin
            prdata_next[CTRL_OPER_LSB +: 2] = operation_selector_reg;
            prdata_next[CTRL_STONLY_BIT] = start_only_option_reg;
         end
         OFS_THRESH: begin
            prdata_next[THR_START_LSB +: 8] = start_threshold_pct_reg;
            prdata_next[THR_BLOCK_LSB +: 8] = blocking_threshold_pct_reg;
         end
         OFS_DELAY: prdata_next[15:0] = trip_delay_ms_reg;
         OFS_STATUS: prdata_next[4:0] = {trip, general_start, ph_start};
         OFS_IRQ_STAT: prdata_next[IRQ_W-1:0] = irq_stat_reg;
         OFS_IRQ_MASK: prdata_next[IRQ_W-1:0] = irq_mask_reg;
         OFS_VOLT_A: prdata_next[VOLT_W-1:0] = phase_a_fundamental_rms;
         OFS_VOLT_B: prdata_next[VOLT_W-1:0] = phase_b_fundamental_rms;
         OFS_VOLT_C: prdata_next[VOLT_W-1:0] = phase_c_fundamental_rms;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data captured in setup so it is stable through access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= prdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Settings; out-of-range writes are clamped to the nearest limit
   assign wr_start = pwdata[THR_START_LSB +: 8];
   assign wr_block = pwdata[THR_BLOCK_LSB +: 8];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         operation_selector_reg <= OPER_ONE_OF_3;
         start_only_option_reg <= 1'b0;
      end else if (wr_en && paddr == OFS_CTRL) begin
         operation_selector_reg <= oper_e'(pwdata[CTRL_OPER_LSB +: 2]);
         start_only_option_reg <= pwdata[CTRL_STONLY_BIT];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_threshold_pct_reg <= START_PCT_DEF;
      end else if (wr_en && paddr == OFS_THRESH) begin
         if (wr_start < START_PCT_MIN) begin
            start_threshold_pct_reg <= START_PCT_MIN;
         end else if (wr_start > START_PCT_MAX) begin
            start_threshold_pct_reg <= START_PCT_MAX;
         end else begin
            start_threshold_pct_reg <= wr_start;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         blocking_threshold_pct_reg <= BLOCK_PCT_DEF;
      end else if (wr_en && paddr == OFS_THRESH) begin
         if (wr_block > BLOCK_PCT_MAX) begin
            blocking_threshold_pct_reg <= BLOCK_PCT_MAX;
         end else begin
            blocking_threshold_pct_reg <= wr_block;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trip_delay_ms_reg <= DELAY_MS_DEF;
      end else if (wr_en && paddr == OFS_DELAY) begin
         if (pwdata[15:0] > DELAY_MS_MAX) begin
            trip_delay_ms_reg <= DELAY_MS_MAX;
         end else begin
            trip_delay_ms_reg <= pwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Phase comparators

   assign active = (operation_selector_reg != OPER_OFF) && !element_disable;

   uv_phase_cmp u_cmp_a (
      .clk_sys(clk_sys),
      .rst(rst),
      .magnitude(phase_a_fundamental_rms),
      .start_pct(start_threshold_pct_reg),
      .block_pct(blocking_threshold_pct_reg),
      .enable(active),
      .started(ph_start[0])
   );
   uv_phase_cmp u_cmp_b (
      .clk_sys(clk_sys),
      .rst(rst),
      .magnitude(phase_b_fundamental_rms),
      .start_pct(start_threshold_pct_reg),
      .block_pct(blocking_threshold_pct_reg),
      .enable(active),
      .started(ph_start[1])
   );
   uv_phase_cmp u_cmp_c (
      .clk_sys(clk_sys),
      .rst(rst),
      .magnitude(phase_c_fundamental_rms),
      .start_pct(start_threshold_pct_reg),
      .block_pct(blocking_threshold_pct_reg),
      .enable(active),
      .started(ph_start[2])
   );

   ////////////////////////////////////////////////////////////////////
   // General start

   assign ph_count = 2'(ph_start[0]) + 2'(ph_start[1]) + 2'(ph_start[2]);

   always_comb begin
      unique case (operation_selector_reg)
         OPER_OFF: gen_start_next = 1'b0;
         OPER_ONE_OF_3: gen_start_next = ph_count >= 2'd1;
         OPER_TWO_OF_3: gen_start_next = ph_count >= 2'd2;
         OPER_ALL: gen_start_next = ph_count == 2'd3;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_a <= 1'b0;
         start_b <= 1'b0;
         start_c <= 1'b0;
         general_start <= 1'b0;
      end else begin
         start_a <= ph_start[0] && active;
         start_b <= ph_start[1] && active;
         start_c <= ph_start[2] && active;
         general_start <= gen_start_next && active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Definite-time delay; a zero setting still trips one cycle after start

   assign ms_tick = ms_tick_cnt_reg == MS_CNT_W'(CYC_PER_MS - 1);
   assign expired = ms_count_reg >= trip_delay_ms_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ms_tick_cnt_reg <= '0;
         ms_count_reg <= 16'h0000;
      end else if (!general_start || !active) begin
         ms_tick_cnt_reg <= '0;
         ms_count_reg <= 16'h0000;
      end else if (ms_tick) begin
         ms_tick_cnt_reg <= '0;
         if (!expired) begin
            ms_count_reg <= ms_count_reg + 16'h0001;
         end
      end else begin
         ms_tick_cnt_reg <= ms_tick_cnt_reg + MS_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trip <= 1'b0;
      end else begin
         trip <= general_start && gen_start_next && active && expired &&
                 !start_only_option_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupts; a new event wins over a same-cycle clear

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         general_start_d_reg <= 1'b0;
         trip_d_reg <= 1'b0;
      end else begin
         general_start_d_reg <= general_start;
         trip_d_reg <= trip;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_stat_reg <= '0;
      end else begin
         if (wr_en && paddr == OFS_IRQ_STAT) begin
            irq_stat_reg <= irq_stat_reg & ~pwdata[IRQ_W-1:0] |
                            {trip && !trip_d_reg,
                             general_start && !general_start_d_reg};
         end else begin
            irq_stat_reg <= irq_stat_reg |
                            {trip && !trip_d_reg,
                             general_start && !general_start_d_reg};
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_mask_reg <= '0;
      end else if (wr_en && paddr == OFS_IRQ_MASK) begin
         irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : uv_element
`default_nettype wire

// File: dv/uv_element_sva.sv
// Port assertions for the undervoltage element.
// Assumes one clk_sys domain; bound to uv_element below.
`timescale 1ns/1ps
`default_nettype none
module uv_element_sva
   import uv_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Measurement and results
   input wire logic [VOLT_W-1:0] phase_a_fundamental_rms,
   input wire logic [VOLT_W-1:0] phase_b_fundamental_rms,
   input wire logic element_disable,
   input wire logic start_a,
   input wire logic start_b,
   input wire logic start_c,
   input wire logic general_start,
   input wire logic trip
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic mapped;
   assign mapped = paddr <= 8'h20 && paddr[1:0] == 2'b00;
   ////////////////////////////////////////////////////////////////////////
   apb_ready_a: assert property (psel |-> pready)
      else $error("pready low in transfer");
   apb_error_a: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   // Settings are hidden here: only 130 percent and up, or zero, are safe
   phase_a_window_a: assert property (
      (phase_a_fundamental_rms >= 16'h8200 ||
      phase_a_fundamental_rms == 16'h0000) [*3] |=> !start_a)
      else $error("phase a started outside window");
   phase_b_block_a: assert property (
      (phase_b_fundamental_rms == 16'h0000) [*3] |=> !start_b)
      else $error("phase b started at zero voltage");
   disable_clear_a: assert property (element_disable [*2] |=>
      !(start_a || start_b || start_c || general_start || trip))
      else $error("output active while disabled");
   gen_phase_a: assert property (general_start |->
      start_a || start_b || start_c)
      else $error("general start with no phase");
   trip_rise_a: assert property ($rose(trip) |->
      $past(general_start) && general_start)
      else $error("trip rose without start");
   trip_drop_a: assert property ($fell(general_start) |=> !trip)
      else $error("trip outlived general start");
endmodule : uv_element_sva
bind uv_element uv_element_sva chk (.clk_sys(clk_sys), .rst(rst),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .phase_a_fundamental_rms(phase_a_fundamental_rms),
   .phase_b_fundamental_rms(phase_b_fundamental_rms),
   .element_disable(element_disable), .start_a(start_a),
   .start_b(start_b), .start_c(start_c),
   .general_start(general_start), .trip(trip));
`default_nettype wire

// File: dv/uv_measure_model.sv
// Upstream measurement stage: one RMS magnitude per phase.
// Assumes clk_sys; level requested in whole percent.
`timescale 1ns/1ps
`default_nettype none
module uv_measure_model
   import uv_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Requested levels
   input wire logic [7:0] pct_a,
   input wire logic [7:0] pct_b,
   input wire logic [7:0] pct_c,
   // Magnitudes
   output logic [VOLT_W-1:0] mag_a,
   output logic [VOLT_W-1:0] mag_b,
   output logic [VOLT_W-1:0] mag_c
);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mag_a <= 16'h0000;
         mag_b <= 16'h0000;
         mag_c <= 16'h0000;
      end else begin
         mag_a <= {pct_a, 8'h00};
         mag_b <= {pct_b, 8'h00};
         mag_c <= {pct_c, 8'h00};
      end
   end
endmodule : uv_measure_model
`default_nettype wire

// File: dv/test_three_phase_undervoltage_protection.sv
// Self-checking bench for the undervoltage element.
// Assumes APB registers and the measurement model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_three_phase_undervoltage_protection;
   import uv_pkg::*;
   logic clk_sys = 0;
   logic rst = 1;
   logic psel = 0, penable = 0, pwrite = 0, element_disable = 0;
   logic [7:0] paddr = 0, pa = 8'h64, pb = 8'h64, pc = 8'h64;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, err, start_a, start_b, start_c;
   logic general_start, trip, irq;
   logic [VOLT_W-1:0] mag_a, mag_b, mag_c;
   logic [7:0] lv [4] = '{8'h0A, 8'h0B, 8'h33, 8'h34};
   int errors = 0, samples_checked = 0, cycles = 0, n;
   always #10 clk_sys = ~clk_sys;
   uv_measure_model src (.clk_sys(clk_sys), .rst(rst), .pct_a(pa),
      .pct_b(pb), .pct_c(pc), .mag_a(mag_a), .mag_b(mag_b), .mag_c(mag_c));
   uv_element DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_a_fundamental_rms(mag_a), .phase_b_fundamental_rms(mag_b),
      .phase_c_fundamental_rms(mag_c), .element_disable(element_disable),
      .start_a(start_a), .start_b(start_b), .start_c(start_c),
      .general_start(general_start), .trip(trip), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task settle;
      repeat (5) @(posedge clk_sys);
      #1;
   endtask : settle
   task conclude;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   // Whole run is near 50200 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 0;
      apb(0, OFS_CTRL, 0);
      `CHK("ctrl", 32'h0000_0001, q)
      apb(0, OFS_THRESH, 0);
      `CHK("thresh", 32'h0000_0A34, q)
      apb(0, OFS_DELAY, 0);
      `CHK("delay", 32'h0000_0064, q)
      apb(0, 8'h24, 0);
      `CHK("unmapped", 33'h1_0000_0000, {err, q})
      // Out-of-range settings clamp
      apb(1, OFS_THRESH, 32'h0000_3010);
      apb(0, OFS_THRESH, 0);
      `CHK("clamp", 32'h0000_141E, q)
      apb(1, OFS_DELAY, 32'h0000_FFFF);
      apb(0, OFS_DELAY, 0);
      `CHK("dmax", 32'h0000_EA60, q)
      // Extremes of both thresholds
      apb(1, OFS_THRESH, 32'h0000_0082);
      pa <= 8'h82;
      pb <= 8'h00;
      settle();
      `CHK("top", 2'b00, {start_b, start_a})
      @(posedge clk_sys);
      pa <= 8'h81;
      settle();
      `CHK("top1", 1'b1, start_a)
      @(posedge clk_sys);
      pa <= 8'h64;
      pb <= 8'h64;
      apb(1, OFS_THRESH, 32'h0000_0A34);
      apb(1, OFS_DELAY, 0);
      apb(1, OFS_THRESH, 32'h0000_0A34);
      // Strict edges of the start window
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         pa <= lv[i];
         settle();
         `CHK("edge", {2{i == 1 || i == 2}}, {start_a, trip})
      end
      @(posedge clk_sys);
      pa <= 8'h28;
      pb <= 8'h28;
      for (int o = 0; o < 4; o++) begin
         apb(1, OFS_CTRL, 32'(o));
         settle();
         `CHK("gen", o == 1 || o == 2, general_start)
         `CHK("ph", {1'b0, {2{o != 0}}}, {start_c, start_b, start_a})
      end
      @(posedge clk_sys);
      pc <= 8'h28;
      settle();
      apb(0, OFS_STATUS, 0);
      `CHK("status", 32'h0000_001F, q)
      apb(0, OFS_VOLT_C, 0);
      `CHK("volt", 32'h0000_2800, q)
      apb(1, OFS_CTRL, 32'h0000_0005);
      settle();
      `CHK("sonly", 2'b10, {general_start, trip})
      @(posedge clk_sys);
      element_disable <= 1;
      settle();
      `CHK("dis", 3'b000, {start_a, general_start, trip})
      @(posedge clk_sys);
      element_disable <= 0;
      settle();
      `CHK("undis", 1'b1, general_start)
      `CHK("irqmask", 1'b0, irq)
      apb(1, OFS_IRQ_MASK, 32'h0000_0003);
      #1;
      `CHK("irq", 1'b1, irq)
      @(posedge clk_sys);
      pa <= 8'h64;
      pb <= 8'h64;
      pc <= 8'h64;
      settle();
      `CHK("drop", 2'b00, {general_start, trip})
      apb(0, OFS_IRQ_STAT, 0);
      `CHK("istat", 32'h0000_0003, q)
      apb(1, OFS_IRQ_STAT, 32'h0000_0003);
      apb(0, OFS_IRQ_STAT, 0);
      `CHK("iclr", 33'h0_0000_0000, {irq, q})
      // One millisecond delay, counted in clocks
      apb(1, OFS_CTRL, 32'h0000_0001);
      apb(1, OFS_DELAY, 32'h0000_0001);
      pa <= 8'h28;
      n = 0;
      while (general_start !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      n = 0;
      while (trip !== 1'b1 && n < 60000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      `CHK("timer", 1'b1, n > 49990 && n < 50010)
      conclude();
   end
endmodule : test_three_phase_undervoltage_protection
`default_nettype wire
